/* File: bench/ebl_err_source.sv */
// Partner model: internal error sources feeding the bank's report port.
// Assumes the bench sets cmd and fire just after a rising edge of aclk.
`timescale 1ns/100ps
module ebl_err_source (
    // Clock
    input wire logic aclk,
    // Command from the bench
    input wire logic fire,
    input wire ebl_pkg::ebl_report_t cmd,
    // Report port
    output ebl_pkg::ebl_report_t err_rep
);
    ebl_pkg::ebl_report_t last_ff = '0;
    // ----
    // Drive
    // ----
    always_ff @(posedge aclk) begin
        if (fire) begin
            last_ff <= cmd;
        end
    end
    // Idle payload is the inverse of the last one, valid low
    assign err_rep = fire ? cmd : {1'b0, ~last_ff[$bits(last_ff)-2:0]};
endmodule // ebl_err_source

/* File: bench/tb_error_bank_logging_threshold.sv */
// Self-checking bench for the error bank.
// Assumes ebl_pkg, ebl_error_bank and ebl_err_source are compiled first.
`timescale 1ns/100ps
`define CHK(nm, exp, got) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) begin \
            n_mismatch++; \
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got); \
        end \
    end
module tb_error_bank_logging_threshold;
    logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d, tv;
    logic [3:0] wstrb = 4'hF, slot, irq_vector_slot;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, fire = 1'b0, deferred_hit = 1'b0;
    logic [1:0] bresp, rresp, rs;
    logic check_exception, protection_fault, threshold_irq;
    logic restart_pointer_good, error_pointer_good, core_state_corrupt;
    ebl_pkg::ebl_report_t cmd = '0, err_rep, e;
    ebl_pkg::ebl_core_t core_in = 3'b110;
    int n_mismatch = 0, n_checks = 0, n_exc = 0, n_irq = 0, n_pf = 0, ne, ni, np, seed;
    logic [31:0] rst_exp [10] = '{32'h0, 32'h0, 32'h0, 32'h0,
        {ebl_pkg::EXTRA_PTR, 24'h00_0000}, {2'b11, 1'b0, ebl_pkg::IRQ_CAPABLE, 28'h000_0000},
        32'h0, 32'h3, ebl_pkg::MORE_BASE + (32'(ebl_pkg::EXTRA_PTR) << 3), 32'h0};

    always #20 aclk = ~aclk;

    ebl_err_source ebl_err_source_inst (.aclk(aclk), .fire(fire), .cmd(cmd), .err_rep(err_rep));
    ebl_error_bank ebl_error_bank_inst (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .err_rep(err_rep),
        .deferred_hit(deferred_hit), .core_in(core_in), .check_exception(check_exception),
        .protection_fault(protection_fault), .threshold_irq(threshold_irq),
        .irq_vector_slot(irq_vector_slot), .restart_pointer_good(restart_pointer_good),
        .error_pointer_good(error_pointer_good), .core_state_corrupt(core_state_corrupt));

    // ----
    // Event pulse counters
    // ----
    always @(negedge aclk) begin
        if (check_exception === 1'b1) n_exc++;
        if (threshold_irq === 1'b1) n_irq++;
        if (protection_fault === 1'b1) n_pf++;
    end

    // ----
    // Bus tasks and expectations
    // ----
    task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
        logic aw_h, w_h, b_h;
        b_h = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b_h) begin
            @(negedge aclk);
            aw_h = awvalid & awready;
            w_h = wvalid & wready;
            b_h = bvalid;
            r = bresp;
            @(posedge aclk);
            if (aw_h) awvalid <= 1'b0;
            if (w_h) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        logic ar_h, r_h;
        r_h = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!r_h) begin
            @(negedge aclk);
            ar_h = arvalid & arready;
            r_h = rvalid;
            v = rdata;
            r = rresp;
            @(posedge aclk);
            if (ar_h) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask

    function automatic ebl_pkg::ebl_report_t mk(input logic uc, df, po, co);
        return {1'b1, 16'($urandom), 16'($urandom), 5'($urandom), uc, df, po, co,
            1'($urandom), 2'($urandom), $urandom, $urandom, 1'($urandom)};
    endfunction

    function automatic logic [31:0] stat_hi(input ebl_pkg::ebl_report_t r, input logic en, ov);
        return {1'b1, ov, r.uncorr, en, r.extra_valid, r.loc_valid, r.corrupt & r.uncorr,
            12'h000, r.deferred & ~r.uncorr, r.poison & r.uncorr, 9'h000, r.loc_kind};
    endfunction

    task automatic send(input ebl_pkg::ebl_report_t r);
        @(posedge aclk);
        cmd <= r;
        fire <= 1'b1;
        @(posedge aclk);
        fire <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask

    task automatic chk_stat(input ebl_pkg::ebl_report_t r, input logic en, ov);
        axr(ebl_pkg::ADR_STAT_LO, d, rs);
        `CHK("status lo", {r.ext, r.code}, d)
        axr(ebl_pkg::ADR_STAT_HI, d, rs);
        `CHK("status hi", stat_hi(r, en, ov), d)
    endtask

    task automatic clr();
        axw(ebl_pkg::ADR_STAT_LO, 32'h0, rs);
        axw(ebl_pkg::ADR_STAT_HI, 32'h0, rs);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        #(40 * 20000);
        n_mismatch++;
        report_and_stop();
    end

    // ----
    // Test sequence
    // ----
    initial begin
        seed = $urandom(32'hc01d558f);
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            axr(8'(i * 4), d, rs);
            `CHK("reset read", rst_exp[i], d)
            `CHK("read resp", (i == 9) ? ebl_pkg::RESP_DECERR : ebl_pkg::RESP_OKAY, rs)
        end
        axw(ebl_pkg::ADR_MASK, 32'hFFFF_FFFF, rs);
        for (int i = 0; i < 4; i++) begin
            e = mk(1'b0, 1'($urandom), 1'b0, 1'b0);
            ne = n_exc;
            send(e);
            `CHK("no exception", ne, n_exc)
            chk_stat(e, 1'b1, 1'b0);
            axr(ebl_pkg::ADR_LOC_LO, d, rs);
            if (e.loc_valid) `CHK("location", e.loc[31:0], d)
            clr();
        end
        send(mk(1'b0, 1'b0, 1'b0, 1'b0));
        e = mk(1'b1, 1'b0, 1'b1, 1'b0);
        ne = n_exc;
        send(e);
        `CHK("uc exception", ne + 1, n_exc)
        chk_stat(e, 1'b1, 1'b1);
        send(mk(1'b0, 1'b1, 1'b0, 1'b0));
        send(mk(1'b1, 1'b0, 1'b0, 1'b0));
        chk_stat(e, 1'b1, 1'b1);
        np = n_pf;
        axw(ebl_pkg::ADR_STAT_HI, 32'h0000_0001, rs);
        `CHK("nonzero write", ebl_pkg::RESP_SLVERR, rs)
        `CHK("fault pulse", np + 1, n_pf)
        chk_stat(e, 1'b1, 1'b1);
        clr();
        axr(ebl_pkg::ADR_STAT_HI, d, rs);
        `CHK("cleared", 32'h0, d)
        e = mk(1'b0, 1'b1, 1'b0, 1'b0);
        ne = n_exc;
        send(e);
        `CHK("deferred quiet", ne, n_exc)
        @(posedge aclk);
        deferred_hit <= 1'b1;
        @(posedge aclk);
        deferred_hit <= 1'b0;
        repeat (2) @(posedge aclk);
        `CHK("escalated exception", ne + 1, n_exc)
        e.uncorr = 1'b1;
        e.deferred = 1'b0;
        chk_stat(e, 1'b1, 1'b0);
        clr();
        e = mk(1'b1, 1'b0, 1'b0, 1'b1);
        send(e);
        `CHK("corrupt", 1'b1, core_state_corrupt)
        `CHK("pointers bad", 2'b00, {error_pointer_good, restart_pointer_good})
        chk_stat(e, 1'b1, 1'b0);
        clr();
        repeat (2) @(posedge aclk);
        `CHK("pointers good", 2'b11, {error_pointer_good, restart_pointer_good})
        core_in.other_corrupt <= 1'b1;
        repeat (2) @(posedge aclk);
        `CHK("other bank", 2'b00, {error_pointer_good, restart_pointer_good})
        core_in.other_corrupt <= 1'b0;
        axw(ebl_pkg::ADR_MASK, 32'h0, rs);
        e = mk(1'b1, 1'b0, 1'b0, 1'b0);
        ne = n_exc;
        send(e);
        `CHK("disabled quiet", ne, n_exc)
        chk_stat(e, 1'b0, 1'b0);
        axw(ebl_pkg::ADR_MASK, 32'hFFFF_FFFF, rs);
        e = mk(1'b0, 1'b0, 1'b0, 1'b0);
        send(e);
        chk_stat(e, 1'b1, 1'b1);
        ce <= 1'b0;
        ne = n_exc;
        send(mk(1'b1, 1'b0, 1'b0, 1'b0));
        ce <= 1'b1;
        `CHK("frozen", ne, n_exc)
        chk_stat(e, 1'b1, 1'b1);
        slot = 4'($urandom);
        tv = {8'h00, slot, 1'b1, 2'b01, 1'b0, 16'hFFFD};
        axw(ebl_pkg::ADR_XTRA_HI, tv, rs);
        axr(ebl_pkg::ADR_XTRA_HI, d, rs);
        `CHK("threshold", {2'b11, 1'b0, ebl_pkg::IRQ_CAPABLE, 4'h0, tv[23:0]}, d)
        `CHK("slot out", slot, irq_vector_slot)
        axw(ebl_pkg::ADR_MASK, 32'h0, rs);
        send(mk(1'b0, 1'b0, 1'b0, 1'b0));
        axr(ebl_pkg::ADR_XTRA_HI, d, rs);
        `CHK("tally disabled", 16'hFFFD, d[15:0])
        axw(ebl_pkg::ADR_MASK, 32'hFFFF_FFFF, rs);
        for (int i = 0; i < 3; i++) begin
            ni = n_irq;
            send(mk(1'b0, 1'b0, 1'b0, 1'b0));
            axr(ebl_pkg::ADR_XTRA_HI, d, rs);
            `CHK("tally", (i == 0) ? 17'h0_FFFE : 17'h1_FFFF, d[16:0])
            `CHK("threshold irq", ni + int'(i == 1), n_irq)
        end
        report_and_stop();
    end
endmodule // tb_error_bank_logging_threshold

/* File: hw/ebl_error_bank.sv */
// Error bank: status logging, replacement, threshold counting, AXI4-Lite.
// Assumes error sources and core status on aclk; one access of each kind.
// Contract
// - Logging writes error code, sets entry good
// - Bit 63 marks valid logged status
// - Logging over valid entry sets bit 62
// - Enabled status displaces disabled status
// - Higher class displaces; enabled uncorrected stays
// - Bit 61 marks uncorrected; else deferred bit
// - Deferred sets bit 44, no exception
// - Deferred escalates to uncorrected when consumed; stays deferred if a non-replacing report arrives the same cycle
// - Bit 43 flags consumed poisoned data
// - Bit 57 flags likely corrupt core state
// - Corrupt state clears both pointer-good bits
// - Bit 58 marks location register valid
// - Bit 59 marks extra information valid
// - Bit 60 marks enabled; disabled no exception
// - Location holds address or internal code
// - Tally counts enabled sources, private register
// - Threshold can raise local interrupt
// - Zero pointer means no further registers
// - Further registers at base plus pointer<<3
// - Valid at 63, pointer at 31:24
// - Threshold fields at documented positions
// - Nonzero status write gives protection fault
// - Log always; exception only if enabled
// - Kind 01 fires on threshold rising
// - Tally saturates at FFFF, sets hit
//
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
module ebl_error_bank (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // AXI4-Lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Error sources and core
    input wire ebl_pkg::ebl_report_t err_rep,
    input wire logic deferred_hit,
    input wire ebl_pkg::ebl_core_t core_in,
    // Events and status
    output logic check_exception,
    output logic protection_fault,
    output logic threshold_irq,
    output logic [3:0] irq_vector_slot,
    output logic restart_pointer_good,
    output logic error_pointer_good,
    output logic core_state_corrupt
);
    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic logic [4:0] ebl_decode(input logic [7:0] a);
        logic [4:0] r;
        r = {1'b0, a[5:2]};
        if (a[1:0] == 2'h0 && a[7:2] < 6'(ebl_pkg::NUM_REGS)) begin
            r[4] = 1'b1;
        end
        return r;
    endfunction

    function automatic logic [1:0] ebl_rank(input logic uc, input logic df);
        return uc ? 2'h2 : (df ? 2'h1 : 2'h0);
    endfunction

    logic [63:0] status_ff, nxt_status, loc_ff;
    logic [31:0] mask_ff;
    logic lock_ff, cnt_on_ff, hit_ff;
    logic [3:0] slot_ff;
    logic [1:0] kind_ff;
    logic [15:0] tally_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff, rdata_ff;
    logic [3:0] wstrb_ff;
    logic aw_have_ff, w_have_ff, bvalid_ff, rvalid_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic exc_ff, fault_ff, irq_ff, rpg_ff, epg_ff;

    // ------------------------------------------------------------
    // Write path
    // ------------------------------------------------------------
    logic wr_go, wr_hit, wr_stat, wr_fault, wr_ok;
    logic [4:0] wr_dec;
    logic [31:0] bmask, wr_val, mw;
    assign wr_go = aw_have_ff && w_have_ff && !bvalid_ff;
    assign wr_dec = ebl_decode(awaddr_ff);
    assign wr_hit = wr_dec[4];
    assign bmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
    assign wr_val = wdata_ff & bmask;
    assign wr_stat = wr_hit && (awaddr_ff == ebl_pkg::ADR_STAT_LO
        || awaddr_ff == ebl_pkg::ADR_STAT_HI);
    assign wr_fault = wr_go && wr_stat && wr_val != 32'h0000_0000;
    assign wr_ok = wr_go && wr_hit && !wr_fault;
    assign s_axi_awready = ce && !aw_have_ff && !bvalid_ff;
    assign s_axi_wready = ce && !w_have_ff && !bvalid_ff;

    logic clr_lo, clr_hi, xtra_wr, mask_wr;
    assign clr_lo = wr_ok && awaddr_ff == ebl_pkg::ADR_STAT_LO;
    assign clr_hi = wr_ok && awaddr_ff == ebl_pkg::ADR_STAT_HI;
    assign xtra_wr = wr_ok && awaddr_ff == ebl_pkg::ADR_XTRA_HI;
    assign mask_wr = wr_ok && awaddr_ff == ebl_pkg::ADR_MASK;
    logic [31:0] thr_hi;
    assign thr_hi = {1'b1, 1'b1, lock_ff, ebl_pkg::IRQ_CAPABLE, 4'h0, slot_ff,
        cnt_on_ff, kind_ff, hit_ff, tally_ff};
    assign mw = (thr_hi & ~bmask) | wr_val;

    // ------------------------------------------------------------
    // Logging and replacement
    // ------------------------------------------------------------
    logic rep_en, rep_uc, rep_df, old_val, replace, escalate;
    logic [63:0] rep_word;
    assign rep_en = mask_ff[err_rep.src];
    assign rep_uc = err_rep.uncorr;
    assign rep_df = err_rep.deferred && !err_rep.uncorr;
    assign old_val = status_ff[ebl_pkg::BIT_VAL];
    assign rep_word = {1'b1, 1'b0, rep_uc, rep_en, err_rep.extra_valid,
        err_rep.loc_valid, err_rep.corrupt && rep_uc, 12'h000, rep_df,
        err_rep.poison && rep_uc, 9'h000, err_rep.loc_kind, err_rep.ext,
        err_rep.code};
    assign replace = !old_val
        || (!(status_ff[ebl_pkg::BIT_UC] && status_ff[ebl_pkg::BIT_EN])
        && ((rep_en && !status_ff[ebl_pkg::BIT_EN])
        || ebl_rank(rep_uc, rep_df) > ebl_rank(status_ff[ebl_pkg::BIT_UC],
        status_ff[ebl_pkg::BIT_DEF])));
    assign escalate = deferred_hit && old_val && status_ff[ebl_pkg::BIT_DEF];

    // Hardware logging wins over a software clear in the same cycle
    always_comb begin
        nxt_status = status_ff;
        if (clr_lo) begin
            nxt_status[31:0] = status_ff[31:0] & ~bmask;
        end
        if (clr_hi) begin
            nxt_status[63:32] = status_ff[63:32] & ~bmask;
        end
        if (escalate) begin
            nxt_status = status_ff;
            nxt_status[ebl_pkg::BIT_UC] = 1'b1;
            nxt_status[ebl_pkg::BIT_DEF] = 1'b0;
        end
        if (err_rep.valid) begin
            if (replace) begin
                nxt_status = rep_word;
            end else begin
                nxt_status = status_ff;
            end
            nxt_status[ebl_pkg::BIT_OVER] = old_val;
        end
    end

    logic nxt_exc;
    assign nxt_exc = (err_rep.valid && rep_uc && rep_en)
        || (escalate && status_ff[ebl_pkg::BIT_EN]);

    // ------------------------------------------------------------
    // Threshold counter
    // ------------------------------------------------------------
    logic sw_thr, cnt_evt, base_hit, nxt_hit, nxt_irq;
    logic [15:0] base_tally, nxt_tally;
    assign sw_thr = xtra_wr && !lock_ff;
    assign cnt_evt = err_rep.valid && cnt_on_ff && rep_en;
    assign base_tally = sw_thr ? mw[15:0] : tally_ff;
    assign base_hit = sw_thr ? mw[16] : hit_ff;
    assign nxt_tally = (cnt_evt && base_tally != ebl_pkg::TALLY_MAX)
        ? base_tally + 16'h0001 : base_tally;
    assign nxt_hit = base_hit || (cnt_evt && base_tally == ebl_pkg::TALLY_PRE);
    assign nxt_irq = nxt_hit && !hit_ff && kind_ff == ebl_pkg::IRQ_LOCAL
        && ebl_pkg::IRQ_CAPABLE;

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [31:0] rd_words [0:ebl_pkg::NUM_REGS-1];
    logic [4:0] rd_dec;
    logic [31:0] more_addr;
    assign rd_dec = ebl_decode(s_axi_araddr);
    assign more_addr = (ebl_pkg::EXTRA_PTR == 8'h00) ? 32'h0000_0000
        : ebl_pkg::MORE_BASE + {21'h00_0000, ebl_pkg::EXTRA_PTR, 3'h0};
    assign rd_words[0] = status_ff[31:0];
    assign rd_words[1] = status_ff[63:32];
    assign rd_words[2] = loc_ff[31:0];
    assign rd_words[3] = loc_ff[63:32];
    assign rd_words[4] = {ebl_pkg::EXTRA_PTR, 24'h00_0000};
    assign rd_words[5] = thr_hi;
    assign rd_words[6] = mask_ff;
    assign rd_words[7] = {30'h0000_0000, epg_ff, rpg_ff};
    assign rd_words[8] = more_addr;
    assign s_axi_arready = ce && !rvalid_ff;

    // ------------------------------------------------------------
    // Bus state
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= ebl_pkg::RESP_OKAY;
            rvalid_ff <= 1'b0;
            rresp_ff <= ebl_pkg::RESP_OKAY;
            rdata_ff <= 32'h0000_0000;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_ff <= 1'b0;
                w_have_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= !wr_hit ? ebl_pkg::RESP_DECERR
                    : (wr_fault ? ebl_pkg::RESP_SLVERR : ebl_pkg::RESP_OKAY);
            end else if (s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                rvalid_ff <= 1'b1;
                rdata_ff <= rd_dec[4] ? rd_words[rd_dec[3:0]] : 32'h0000_0000;
                rresp_ff <= rd_dec[4] ? ebl_pkg::RESP_OKAY : ebl_pkg::RESP_DECERR;
            end else if (s_axi_rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Bank state
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_ff <= ebl_pkg::STAT_RST;
            loc_ff <= ebl_pkg::LOC_RST;
            mask_ff <= ebl_pkg::MASK_RST;
            exc_ff <= 1'b0;
            fault_ff <= 1'b0;
        end else if (ce) begin
            status_ff <= nxt_status;
            if (err_rep.valid && replace && err_rep.loc_valid) begin
                loc_ff <= err_rep.loc;
            end
            if (mask_wr) begin
                mask_ff <= (mask_ff & ~bmask) | wr_val;
            end
            exc_ff <= nxt_exc;
            fault_ff <= wr_fault;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lock_ff <= 1'b0;
            slot_ff <= ebl_pkg::SLOT_RST;
            cnt_on_ff <= 1'b0;
            kind_ff <= ebl_pkg::IRQ_NONE;
            hit_ff <= 1'b0;
            tally_ff <= ebl_pkg::TALLY_RST;
            irq_ff <= 1'b0;
        end else if (ce) begin
            if (xtra_wr) begin
                lock_ff <= mw[29];
            end
            if (sw_thr) begin
                slot_ff <= mw[23:20];
                cnt_on_ff <= mw[19];
                kind_ff <= mw[18:17];
            end
            hit_ff <= nxt_hit;
            tally_ff <= nxt_tally;
            irq_ff <= nxt_irq;
        end
    end

    // Pointer-good bits follow the core unless any bank is corrupt
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rpg_ff <= 1'b0;
            epg_ff <= 1'b0;
        end else if (ce) begin
            rpg_ff <= core_in.restart_ok && !status_ff[ebl_pkg::BIT_CORR]
                && !core_in.other_corrupt;
            epg_ff <= core_in.error_ptr_ok && !status_ff[ebl_pkg::BIT_CORR]
                && !core_in.other_corrupt;
        end
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp = rresp_ff;
    assign s_axi_rdata = rdata_ff;
    assign check_exception = exc_ff;
    assign protection_fault = fault_ff;
    assign threshold_irq = irq_ff;
    assign irq_vector_slot = slot_ff;
    assign restart_pointer_good = rpg_ff;
    assign error_pointer_good = epg_ff;
    assign core_state_corrupt = status_ff[ebl_pkg::BIT_CORR];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !ce);
    logic [15:0] stat_code;
    logic stuck_uc;
    assign stat_code = status_ff[15:0];
    assign stuck_uc = err_rep.valid && old_val && status_ff[ebl_pkg::BIT_UC]
        && status_ff[ebl_pkg::BIT_EN];

    property p_log_valid;
        err_rep.valid && !old_val |=> status_ff[ebl_pkg::BIT_VAL]
            && stat_code == $past(err_rep.code);
    endproperty
    a_log_valid: assert property (p_log_valid) else $error("log not valid");

    property p_over;
        err_rep.valid && old_val |=> status_ff[ebl_pkg::BIT_OVER];
    endproperty
    a_over: assert property (p_over) else $error("over not set");

    property p_keep_uc;
        stuck_uc |=> $stable(stat_code) && status_ff[ebl_pkg::BIT_UC];
    endproperty
    a_keep_uc: assert property (p_keep_uc) else $error("enabled uc replaced");

    property p_no_exc;
        err_rep.valid && !(rep_en && rep_uc) && !escalate |=> !check_exception;
    endproperty
    a_no_exc: assert property (p_no_exc) else $error("spurious exception");

    property p_poison;
        status_ff[ebl_pkg::BIT_POIS] || status_ff[ebl_pkg::BIT_CORR]
            |-> status_ff[ebl_pkg::BIT_UC];
    endproperty
    a_poison: assert property (p_poison) else $error("flag without uc");

    property p_fault;
        wr_go && wr_stat && wr_val != 32'h0000_0000
            |=> protection_fault && s_axi_bresp == ebl_pkg::RESP_SLVERR;
    endproperty
    a_fault: assert property (p_fault) else $error("no fault");

    property p_sat;
        tally_ff == ebl_pkg::TALLY_MAX && !sw_thr |=> tally_ff == ebl_pkg::TALLY_MAX;
    endproperty
    a_sat: assert property (p_sat) else $error("tally rolled");

    property p_global;
        status_ff[ebl_pkg::BIT_CORR] |=> !restart_pointer_good && !error_pointer_good;
    endproperty
    a_global: assert property (p_global) else $error("pointer good kept");

    property p_irq;
        $rose(hit_ff) && $past(kind_ff) == ebl_pkg::IRQ_LOCAL |-> threshold_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("no threshold irq");

    property p_defer_up;
        escalate && !err_rep.valid |=> status_ff[ebl_pkg::BIT_UC]
            && !status_ff[ebl_pkg::BIT_DEF];
    endproperty
    a_defer_up: assert property (p_defer_up) else $error("no escalation");

    property p_cv_over;
        err_rep.valid && old_val && replace;
    endproperty
    c_cv_over: cover property (p_cv_over);
    property p_cv_hit;
        $rose(hit_ff);
    endproperty
    c_cv_hit: cover property (p_cv_hit);
    property p_cv_fault;
        wr_fault;
    endproperty
    c_cv_fault: cover property (p_cv_fault);
endmodule // ebl_error_bank

/* File: hw/ebl_pkg.sv */
// Constants and carrier types for one error-reporting bank.
// Assumes a single clock domain and AXI4-Lite register access.
package ebl_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADR_STAT_LO = 8'h00;
    localparam logic [7:0] ADR_STAT_HI = 8'h04;
    localparam logic [7:0] ADR_LOC_LO = 8'h08;
    localparam logic [7:0] ADR_LOC_HI = 8'h0C;
    localparam logic [7:0] ADR_XTRA_LO = 8'h10;
    localparam logic [7:0] ADR_XTRA_HI = 8'h14;
    localparam logic [7:0] ADR_MASK = 8'h18;
    localparam logic [7:0] ADR_GLOBAL = 8'h1C;
    localparam logic [7:0] ADR_MORE = 8'h20;
    localparam int NUM_REGS = 9;
    // ------------------------------------------------------------
    // Status field positions
    // ------------------------------------------------------------
    localparam int BIT_VAL = 63;
    localparam int BIT_OVER = 62;
    localparam int BIT_UC = 61;
    localparam int BIT_EN = 60;
    localparam int BIT_XTRA = 59;
    localparam int BIT_LOC = 58;
    localparam int BIT_CORR = 57;
    localparam int BIT_DEF = 44;
    localparam int BIT_POIS = 43;
    // ------------------------------------------------------------
    // Threshold format and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] TALLY_MAX = 16'hFFFF;
    localparam logic [15:0] TALLY_PRE = 16'hFFFE;
    localparam logic [1:0] IRQ_NONE = 2'h0;
    localparam logic [1:0] IRQ_LOCAL = 2'h1;
    localparam logic [7:0] EXTRA_PTR = 8'h01;
    localparam logic IRQ_CAPABLE = 1'b1;
    localparam logic [31:0] MORE_BASE = 32'hC000_0400;
    localparam logic [63:0] STAT_RST = 64'h0000_0000_0000_0000;
    localparam logic [63:0] LOC_RST = 64'h0000_0000_0000_0000;
    localparam logic [31:0] MASK_RST = 32'h0000_0000;
    localparam logic [15:0] TALLY_RST = 16'h0000;
    localparam logic [3:0] SLOT_RST = 4'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic [15:0] code;
        logic [15:0] ext;
        logic [4:0] src;
        logic uncorr;
        logic deferred;
        logic poison;
        logic corrupt;
        logic loc_valid;
        logic [1:0] loc_kind;
        logic [63:0] loc;
        logic extra_valid;
    } ebl_report_t;
    typedef struct packed {
        logic restart_ok;
        logic error_ptr_ok;
        logic other_corrupt;
    } ebl_core_t;
endpackage
